// ---- rtl/spvp_port.v ----
// Serial program/verify port: pin synchronisers, mode entry, the 20-bit
// instruction shifter, table pointer and latch, read path and a two-entry
// stream buffer toward the core and the flash controller.
// Assumes the core drives sfr_* on clk and answers rd_addr within a cycle.
`timescale 1ns/1ps
`include "spvp_regs.vh"

module spvp_port #(
   parameter BIG_PART = 0,
   // Device code value is arbitrary.
   parameter [15:0] DEVICE_CODE = 16'h0A5C
) (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Programming pins
   input wire serial_prog_clock,
   input wire serial_prog_data_in,
   output reg serial_prog_data_out,
   output reg serial_prog_data_oe_b,
   input wire master_clear_high_voltage_pin,
   input wire master_clear_logic_high,
   input wire low_voltage_select_pin,
   // Configuration
   input wire low_voltage_mode_enable_bit,
   input wire [4:0] code_protect,
   // Mode status
   output reg prog_mode_active,
   output reg low_voltage_mode_active,
   output reg io_hold_hiz,
   output reg port_b5_select_pin_dedicated,
   // Memory read port
   output wire [21:0] rd_addr,
   input wire [7:0] rd_data,
   // Core register port
   input wire sfr_we,
   input wire [11:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // Instruction and write stream
   output wire cmd_valid,
   input wire cmd_ready,
   output wire [1:0] cmd_kind,
   output wire [21:0] cmd_addr,
   output wire [15:0] cmd_data,
   output wire link_stall,
   // Programming and erase timing
   output reg fourth_clock_high,
   output reg fourth_clock_rise
);

   localparam MODE_RUN = 2'h0;
   localparam MODE_HV = 2'h1;
   localparam MODE_LV = 2'h2;
   localparam ENTRY_W = 40;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Bit order: 0 data, 1 clock, 2 select, 3 logic high, 4 high voltage.
   reg [4:0] pin_s1_q;
   reg [4:0] pin_s2_q;
   reg [4:0] pin_s3_q;
   wire [4:0] pin_raw;

   assign pin_raw = {master_clear_high_voltage_pin, master_clear_logic_high,
                     low_voltage_select_pin, serial_prog_clock,
                     serial_prog_data_in};

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
         pin_s3_q <= 5'h00;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   wire sdi = pin_s2_q[0];
   wire sck = pin_s2_q[1];
   wire sck_rise = pin_s2_q[1] & ~pin_s3_q[1];
   wire sck_fall = ~pin_s2_q[1] & pin_s3_q[1];
   wire hv_rise = pin_s2_q[4] & ~pin_s3_q[4];
   wire lh_rise = pin_s2_q[3] & ~pin_s3_q[3];

   // ****************************************
   // Mode entry and exit
   // ****************************************
   reg [1:0] mode_q;
   reg [1:0] mode_d;
   wire in_mode = (mode_q != MODE_RUN);

   always @* begin
      mode_d = mode_q;
      case (mode_q)
         MODE_RUN: begin
            if (hv_rise && !sck && !sdi) begin
               mode_d = MODE_HV;
            end else if (low_voltage_mode_enable_bit && pin_s2_q[2] && lh_rise &&
                         !sck && !sdi) begin
               mode_d = MODE_LV;
            end
         end
         MODE_HV: begin
            if (!pin_s2_q[4]) begin
               mode_d = MODE_RUN;
            end
         end
         MODE_LV: begin
            if (!pin_s2_q[3] || !pin_s2_q[2]) begin
               mode_d = MODE_RUN;
            end
         end
         default: begin
            mode_d = MODE_RUN;
         end
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= MODE_RUN;
         prog_mode_active <= 1'b0;
         low_voltage_mode_active <= 1'b0;
         io_hold_hiz <= 1'b0;
         port_b5_select_pin_dedicated <= 1'b0;
      end else begin
         mode_q <= mode_d;
         prog_mode_active <= (mode_d != MODE_RUN);
         low_voltage_mode_active <= (mode_d == MODE_LV);
         io_hold_hiz <= (mode_d != MODE_RUN);
         port_b5_select_pin_dedicated <= (mode_d == MODE_LV);
      end
   end

   // ****************************************
   // Instruction shifter
   // ****************************************
   reg [4:0] bit_q;
   reg [19:0] shift_q;
   reg [3:0] cmd_q;
   reg pend_q;
   reg [ENTRY_W-1:0] pend_entry_q;

   wire take_bit = in_mode & sck_fall & ~pend_q;
   wire cmd_done = take_bit & (bit_q == `SPVP_LAST_CMD_BIT);
   wire word_done = take_bit & (bit_q == `SPVP_LAST_BIT);
   wire [3:0] new_cmd = {sdi, shift_q[19:17]};
   wire [19:0] new_word = {sdi, shift_q[19:1]};
   wire [15:0] operand = new_word[19:4];
   wire cmd_is_rd = (cmd_q == `SPVP_CMD_SHIFT_LATCH) || (cmd_q[3:2] == 2'b10);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_q <= 5'h00;
         shift_q <= 20'h00000;
         cmd_q <= 4'h0;
      end else if (!in_mode) begin
         bit_q <= 5'h00;
      end else if (take_bit) begin
         shift_q <= new_word;
         if (bit_q == `SPVP_LAST_BIT) begin
            bit_q <= 5'h00;
         end else begin
            bit_q <= bit_q + 5'h01;
         end
         if (cmd_done) begin
            cmd_q <= new_cmd;
         end
      end
   end

   // ****************************************
   // Data pin driver
   // ****************************************
   // Released unless inside the output byte, so a collision with the
   // programmer lasts at most three system clocks around the turnaround.
   reg [7:0] latch_q;
   wire [2:0] out_idx = bit_q[2:0] - `SPVP_OUT_IDX_BIAS;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         serial_prog_data_out <= 1'b0;
         serial_prog_data_oe_b <= 1'b1;
      end else if (!in_mode) begin
         serial_prog_data_oe_b <= 1'b1;
      end else if (sck_rise) begin
         if (cmd_is_rd && bit_q >= `SPVP_FIRST_OUT_BIT) begin
            serial_prog_data_out <= latch_q[out_idx];
            serial_prog_data_oe_b <= 1'b0;
         end else begin
            serial_prog_data_oe_b <= 1'b1;
         end
      end else if (sck_fall && bit_q == `SPVP_LAST_BIT) begin
         serial_prog_data_oe_b <= 1'b1;
      end
   end

   // ****************************************
   // Fourth clock timing
   // ****************************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fourth_clock_high <= 1'b0;
         fourth_clock_rise <= 1'b0;
      end else begin
         fourth_clock_high <= in_mode & sck & (bit_q == `SPVP_LAST_CMD_BIT);
         fourth_clock_rise <= in_mode & sck_rise & (bit_q == `SPVP_LAST_CMD_BIT);
      end
   end

   // ****************************************
   // Read address decode
   // ****************************************
   reg [21:0] ptr_q;
   reg [21:0] ptr_d;
   reg [1:0] rd_step_q;
   reg [7:0] rd_value;
   reg [2:0] zone;
   wire [21:0] boot_end = BIG_PART ? `SPVP_BOOT_END_32K : `SPVP_BOOT_END_8K;
   wire [21:0] code_end = BIG_PART ? `SPVP_CODE_END_32K : `SPVP_CODE_END_8K;
   wire [1:0] blk = BIG_PART ? ptr_q[14:13] : {1'b0, ptr_q[12]};

   assign rd_addr = ptr_q;

   always @* begin
      zone = 3'h0;
      rd_value = 8'h00;
      if (ptr_q <= code_end) begin
         if (ptr_q > boot_end) begin
            zone = {1'b0, blk} + 3'h1;
         end
         // Each zone has its own protect bit.
         rd_value = code_protect[zone] ? 8'h00 : rd_data;
      end else if (ptr_q >= `SPVP_ID_FIRST && ptr_q <= `SPVP_ID_LAST) begin
         rd_value = rd_data;
      end else if (ptr_q >= `SPVP_CFG_FIRST && ptr_q <= `SPVP_CFG_LAST) begin
         rd_value = rd_data;
      end else if (ptr_q >= `SPVP_DEVID_FIRST) begin
         rd_value = ptr_q[0] ? DEVICE_CODE[15:8] : DEVICE_CODE[7:0];
      end
   end

   // ****************************************
   // Table pointer and latch
   // ****************************************
   always @* begin
      ptr_d = ptr_q;
      if (sfr_we && sfr_addr == `SPVP_OFS_TBL_LOW) begin
         ptr_d[`SPVP_PTR_LOW_MSB:`SPVP_PTR_LOW_LSB] = sfr_wdata;
      end
      if (sfr_we && sfr_addr == `SPVP_OFS_TBL_HIGH) begin
         ptr_d[`SPVP_PTR_HIGH_MSB:`SPVP_PTR_HIGH_LSB] = sfr_wdata;
      end
      if (sfr_we && sfr_addr == `SPVP_OFS_TBL_UPPER) begin
         ptr_d[`SPVP_PTR_UPPER_MSB:`SPVP_PTR_UPPER_LSB] = sfr_wdata[5:0];
      end
      if (cmd_done && new_cmd == `SPVP_CMD_RD_PREINC) begin
         ptr_d = ptr_q + 22'h000001;
      end
      if (rd_step_q == 2'h2 && cmd_q == `SPVP_CMD_RD_POSTINC) begin
         ptr_d = ptr_q + 22'h000001;
      end
      if (rd_step_q == 2'h2 && cmd_q == `SPVP_CMD_RD_POSTDEC) begin
         ptr_d = ptr_q - 22'h000001;
      end
      if (word_done && (cmd_q == `SPVP_CMD_WR_INC2 ||
                        cmd_q == `SPVP_CMD_WR_PROG_INC2)) begin
         ptr_d = ptr_q + 22'h000002;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_q <= `SPVP_RST_TBL_PTR;
         latch_q <= `SPVP_RST_TBL_LATCH;
         rd_step_q <= 2'h0;
      end else begin
         ptr_q <= ptr_d;
         if (cmd_done && new_cmd[3:2] == 2'b10) begin
            rd_step_q <= 2'h1;
         end else if (rd_step_q == 2'h1) begin
            rd_step_q <= 2'h2;
         end else begin
            rd_step_q <= 2'h0;
         end
         if (rd_step_q == 2'h2) begin
            latch_q <= rd_value;
         end else if (sfr_we && sfr_addr == `SPVP_OFS_TBL_LATCH) begin
            latch_q <= sfr_wdata;
         end
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
      end else begin
         case (sfr_addr)
            `SPVP_OFS_TBL_LOW: sfr_rdata <= ptr_q[7:0];
            `SPVP_OFS_TBL_HIGH: sfr_rdata <= ptr_q[15:8];
            `SPVP_OFS_TBL_UPPER: sfr_rdata <= {2'b00, ptr_q[21:16]};
            `SPVP_OFS_TBL_LATCH: sfr_rdata <= latch_q;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // Pending entry
   // ****************************************
   // A finished word waits here while the buffer is full; the shifter
   // ignores clock edges meanwhile, so the programmer must watch link_stall.
   reg [1:0] fifo_cnt_q;
   wire fifo_full = (fifo_cnt_q == 2'h2);
   wire push = pend_q & ~fifo_full;
   reg [1:0] kind_d;

   always @* begin
      case (cmd_q)
         `SPVP_CMD_WR_PROG_INC2: kind_d = `SPVP_KIND_WRITE_PROG;
         `SPVP_CMD_WR_PROG: kind_d = `SPVP_KIND_WRITE_PROG;
         `SPVP_CMD_CORE: kind_d = `SPVP_KIND_CORE;
         default: kind_d = `SPVP_KIND_WRITE;
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= 1'b0;
         pend_entry_q <= {ENTRY_W{1'b0}};
      end else if (word_done && (cmd_q == `SPVP_CMD_CORE || cmd_q[3:2] == 2'b11)) begin
         pend_q <= 1'b1;
         pend_entry_q <= {kind_d, ptr_q, operand};
      end else if (push) begin
         pend_q <= 1'b0;
      end
   end

   assign link_stall = pend_q;

   // ****************************************
   // Two-entry stream buffer
   // ****************************************
   reg [ENTRY_W-1:0] fifo_mem_q [0:1];
   reg fifo_wp_q;
   reg fifo_rp_q;
   wire pop = cmd_valid & cmd_ready;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_entry
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               fifo_mem_q[gi] <= {ENTRY_W{1'b0}};
            end else if (push && fifo_wp_q == gi) begin
               fifo_mem_q[gi] <= pend_entry_q;
            end
         end
      end
   endgenerate

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo_wp_q <= 1'b0;
         fifo_rp_q <= 1'b0;
         fifo_cnt_q <= 2'h0;
      end else begin
         if (push) begin
            fifo_wp_q <= ~fifo_wp_q;
         end
         if (pop) begin
            fifo_rp_q <= ~fifo_rp_q;
         end
         if (push && !pop) begin
            fifo_cnt_q <= fifo_cnt_q + 2'h1;
         end else if (pop && !push) begin
            fifo_cnt_q <= fifo_cnt_q - 2'h1;
         end
      end
   end

   assign cmd_valid = (fifo_cnt_q != 2'h0);
   assign {cmd_kind, cmd_addr, cmd_data} = fifo_mem_q[fifo_rp_q];

endmodule

// ---- rtl/spvp_regs.vh ----
// Register offsets, address map, commands and counts of the serial
// program/verify port.
// Assumes inclusion by the port module, the property module and the bench, by bare name.
`ifndef SPVP_REGS_VH
`define SPVP_REGS_VH

// ****************************************
// Core-visible register offsets
// ****************************************
`define SPVP_OFS_TBL_LOW 12'hFF6
`define SPVP_OFS_TBL_HIGH 12'hFF7
`define SPVP_OFS_TBL_UPPER 12'hFF8
`define SPVP_OFS_TBL_LATCH 12'hFF5
`define SPVP_RST_TBL_PTR 22'h000000
`define SPVP_RST_TBL_LATCH 8'h00

// ****************************************
// Table pointer field positions
// ****************************************
`define SPVP_PTR_LOW_MSB 7
`define SPVP_PTR_LOW_LSB 0
`define SPVP_PTR_HIGH_MSB 15
`define SPVP_PTR_HIGH_LSB 8
`define SPVP_PTR_UPPER_MSB 21
`define SPVP_PTR_UPPER_LSB 16

// ****************************************
// Address map
// ****************************************
`define SPVP_BOOT_END_8K 22'h0001FF
`define SPVP_CODE_END_8K 22'h001FFF
`define SPVP_BOOT_END_32K 22'h0007FF
`define SPVP_CODE_END_32K 22'h007FFF
`define SPVP_ID_FIRST 22'h200000
`define SPVP_ID_LAST 22'h200007
`define SPVP_CFG_FIRST 22'h300000
`define SPVP_CFG_LAST 22'h30000D
`define SPVP_DEVID_FIRST 22'h3FFFFE

// ****************************************
// Four-bit commands
// ****************************************
`define SPVP_CMD_CORE 4'h0
`define SPVP_CMD_SHIFT_LATCH 4'h2
`define SPVP_CMD_RD 4'h8
`define SPVP_CMD_RD_POSTINC 4'h9
`define SPVP_CMD_RD_POSTDEC 4'hA
`define SPVP_CMD_RD_PREINC 4'hB
`define SPVP_CMD_WR 4'hC
`define SPVP_CMD_WR_INC2 4'hD
`define SPVP_CMD_WR_PROG_INC2 4'hE
`define SPVP_CMD_WR_PROG 4'hF

// ****************************************
// Stream entry kinds
// ****************************************
`define SPVP_KIND_CORE 2'h0
`define SPVP_KIND_WRITE 2'h1
`define SPVP_KIND_WRITE_PROG 2'h2

// ****************************************
// Bit counts of one instruction
// ****************************************
`define SPVP_LAST_BIT 5'h13
`define SPVP_LAST_CMD_BIT 5'h03
`define SPVP_FIRST_OUT_BIT 5'h0C
`define SPVP_OUT_IDX_BIAS 3'h4

`endif

// ---- verif/spvp_port_properties.sv ----
// Concurrent checks on the ports of the serial program/verify port.
// Assumes one clock domain, clk, with the asynchronous reset rst_b.
`timescale 1ns/1ps
`include "spvp_regs.vh"

module spvp_port_properties (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Pins and mode
   input wire serial_prog_data_oe_b,
   input wire low_voltage_mode_enable_bit,
   input wire prog_mode_active,
   input wire low_voltage_mode_active,
   input wire io_hold_hiz,
   input wire port_b5_select_pin_dedicated,
   input wire fourth_clock_high,
   input wire fourth_clock_rise,
   // Core register port
   input wire [11:0] sfr_addr,
   input wire [7:0] sfr_rdata,
   // Stream
   input wire cmd_valid,
   input wire cmd_ready,
   input wire [1:0] cmd_kind,
   input wire [21:0] cmd_addr,
   input wire [15:0] cmd_data
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   AST_OE_ONLY_IN_MODE: assert property (!serial_prog_data_oe_b |-> prog_mode_active)
      else $error("data pin driven outside program mode");
   AST_OE_HOLDS_BYTE: assert property ($fell(serial_prog_data_oe_b) |-> !serial_prog_data_oe_b[*8])
      else $error("output byte drive dropped early");
   AST_LV_IN_MODE: assert property (low_voltage_mode_active |-> prog_mode_active)
      else $error("low-voltage flag without program mode");
   AST_LV_NEEDS_ENABLE: assert property ($rose(low_voltage_mode_active) |-> low_voltage_mode_enable_bit)
      else $error("low-voltage mode entered while disabled");
   AST_B5_DEDICATED: assert property (port_b5_select_pin_dedicated == low_voltage_mode_active)
      else $error("select pin dedication differs from mode");
   AST_HIZ_IN_MODE: assert property (io_hold_hiz == prog_mode_active)
      else $error("high-impedance hold differs from mode");
   AST_HEAD_STANDS: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_kind) && $stable(cmd_addr) && $stable(cmd_data))
      else $error("stream head changed while stalled");
   AST_KIND_LEGAL: assert property (cmd_valid |-> cmd_kind != 2'h3)
      else $error("illegal stream kind");
   AST_RISE_PULSE: assert property (fourth_clock_rise |=> !fourth_clock_rise)
      else $error("fourth clock pulse longer than one cycle");
   AST_FOURTH_IN_MODE: assert property (fourth_clock_high |-> prog_mode_active)
      else $error("fourth clock flag outside program mode");
   AST_UNMAPPED_ZERO: assert property (!(sfr_addr inside {`SPVP_OFS_TBL_LOW, `SPVP_OFS_TBL_HIGH,
      `SPVP_OFS_TBL_UPPER, `SPVP_OFS_TBL_LATCH}) |=> sfr_rdata == 8'h00)
      else $error("unmapped register read not zero");
   AST_UPPER_SIX: assert property (sfr_addr == `SPVP_OFS_TBL_UPPER |=> sfr_rdata[7:6] == 2'h0)
      else $error("upper pointer byte has bits above 21");
endmodule

bind spvp_port spvp_port_properties i_spvp_port_properties (.clk, .rst_b, .serial_prog_data_oe_b,
   .low_voltage_mode_enable_bit, .prog_mode_active, .low_voltage_mode_active, .io_hold_hiz,
   .port_b5_select_pin_dedicated, .fourth_clock_high, .fourth_clock_rise, .sfr_addr,
   .sfr_rdata, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr, .cmd_data);

// ---- verif/spvp_prog_model.sv ----
// Programmer model: programming clock, data line and mode entry pins.
// Assumes a 4 ns bench clock; one link clock phase is ten such cycles, the fourth high phase hold4 cycles.
`timescale 1ns/1ps

module spvp_prog_model (
   // Clock
   input wire clk,
   // Device side of the data pin
   input wire dev_out,
   input wire dev_oe_b,
   // Programming pins
   output reg prog_clock,
   output wire prog_line,
   output reg hv_pin,
   output reg logic_high_pin,
   output reg select_pin
);
   reg drv_en;
   reg drv_val;
   reg float_q;

   // A released line toggles each clock, but samples fall 20 clocks apart, so a missing device drive reads as all zeros or all ones.
   assign prog_line = !dev_oe_b ? dev_out : (drv_en ? drv_val : float_q);

   initial begin
      prog_clock = 1'b0;
      hv_pin = 1'b0;
      logic_high_pin = 1'b0;
      select_pin = 1'b0;
      drv_en = 1'b1;
      drv_val = 1'b0;
      float_q = 1'b0;
   end

   always @(posedge clk) begin
      float_q <= ~float_q;
   end

   // ****************************************
   // Pin sequences
   // ****************************************
   task half(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask

   task enter(input lv);
      begin
         prog_clock = 1'b0;
         drv_val = 1'b0;
         select_pin = lv;
         half(10);
         if (lv) logic_high_pin = 1'b1;
         else hv_pin = 1'b1;
         half(10);
      end
   endtask

   task leave;
      begin
         hv_pin = 1'b0;
         logic_high_pin = 1'b0;
         select_pin = 1'b0;
         half(10);
      end
   endtask

   // The clock stands low between instructions.
   task xfer(input [3:0] cmd, input [15:0] opnd, input integer hold4, output [7:0] rd);
      reg [19:0] word;
      reg rd_cmd;
      integer i;
      begin
         word = {opnd, cmd};
         rd_cmd = (cmd == 4'h2) || (cmd[3:2] == 2'h2);
         rd = 8'h00;
         for (i = 0; i < 20; i = i + 1) begin
            drv_en = !(rd_cmd && i >= 12);
            drv_val = word[i];
            prog_clock = 1'b1;
            half(i == 3 ? hold4 : 10);
            if (!drv_en) rd[i - 12] = prog_line;
            prog_clock = 1'b0;
            half(10);
         end
         drv_en = 1'b1;
         drv_val = 1'b0;
      end
   endtask
endmodule

// ---- verif/spvp_port_tb.sv ----
// Self-checking bench of the serial program/verify port.
// Assumes the programmer model and a memory image made from the address.
`timescale 1ns/1ps
`include "spvp_regs.vh"

module spvp_port_tb;
   // Device code value is arbitrary.
   localparam [15:0] DEV_CODE = 16'hC3E1;
   reg clk, rst_b, sfr_we, cmd_ready, low_voltage_mode_enable_bit;
   reg [4:0] code_protect;
   reg [11:0] sfr_addr;
   reg [7:0] sfr_wdata;
   wire serial_prog_clock, serial_prog_data_in, serial_prog_data_out, serial_prog_data_oe_b;
   wire master_clear_high_voltage_pin, master_clear_logic_high, low_voltage_select_pin;
   wire prog_mode_active, low_voltage_mode_active, io_hold_hiz, port_b5_select_pin_dedicated;
   wire cmd_valid, link_stall, fourth_clock_high, fourth_clock_rise;
   wire [21:0] rd_addr, cmd_addr;
   wire [7:0] rd_data, sfr_rdata;
   wire [1:0] cmd_kind;
   wire [15:0] cmd_data;
   integer num_errors, n_tests;

   function [7:0] mem(input [21:0] a);
      mem = a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]} ^ 8'h5A;
   endfunction
   assign rd_data = mem(rd_addr);

   spvp_port #(.BIG_PART(0), .DEVICE_CODE(DEV_CODE)) i_spvp_port (.clk, .rst_b,
      .serial_prog_clock, .serial_prog_data_in, .serial_prog_data_out, .serial_prog_data_oe_b,
      .master_clear_high_voltage_pin, .master_clear_logic_high, .low_voltage_select_pin,
      .low_voltage_mode_enable_bit, .code_protect, .prog_mode_active, .low_voltage_mode_active,
      .io_hold_hiz, .port_b5_select_pin_dedicated, .rd_addr, .rd_data, .sfr_we, .sfr_addr,
      .sfr_wdata, .sfr_rdata, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr, .cmd_data,
      .link_stall, .fourth_clock_high, .fourth_clock_rise);

   spvp_prog_model i_prog (.clk(clk), .dev_out(serial_prog_data_out),
      .dev_oe_b(serial_prog_data_oe_b), .prog_clock(serial_prog_clock),
      .prog_line(serial_prog_data_in), .hv_pin(master_clear_high_voltage_pin),
      .logic_high_pin(master_clear_logic_high), .select_pin(low_voltage_select_pin));

   // ****************************************
   // Shared tasks
   // ****************************************
   task step;
      begin
         @(posedge clk);
         #1;
      end
   endtask

   task chk(input [23:0] g, input [23:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask

   task sfr_wr(input [11:0] a, input [7:0] d);
      begin
         sfr_we = 1'b1;
         sfr_addr = a;
         sfr_wdata = d;
         step;
         sfr_we = 1'b0;
         step;
      end
   endtask

   task sfr_rd(input [11:0] a, input [7:0] e);
      begin
         sfr_addr = a;
         step;
         chk(24'(sfr_rdata), 24'(e));
      end
   endtask

   task setp(input [21:0] p);
      begin
         sfr_wr(`SPVP_OFS_TBL_UPPER, {2'h0, p[21:16]});
         sfr_wr(`SPVP_OFS_TBL_HIGH, p[15:8]);
         sfr_wr(`SPVP_OFS_TBL_LOW, p[7:0]);
      end
   endtask

   task pop(input [1:0] k, input [21:0] a, input [15:0] d);
      integer n;
      begin
         for (n = 0; n < 40 && cmd_valid !== 1'b1; n = n + 1) step;
         chk(24'(cmd_valid), 24'h000001);
         chk(24'(cmd_kind), 24'(k));
         chk(24'(cmd_addr), 24'(a));
         chk(24'(cmd_data), 24'(d));
         cmd_ready = 1'b1;
         step;
         cmd_ready = 1'b0;
         step;
      end
   endtask

   task rdchk(input [21:0] a, input [7:0] e);
      reg [7:0] b;
      begin
         setp(a);
         i_prog.xfer(`SPVP_CMD_RD, 16'h0000, 10, b);
         chk(24'(b), 24'(e));
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      begin
         chk(24'(serial_prog_data_oe_b), 24'h000001);
         chk(24'(prog_mode_active), 24'h000000);
         chk(24'(rd_addr), 24'h000000);
         sfr_rd(`SPVP_OFS_TBL_LOW, 8'h00);
         sfr_rd(`SPVP_OFS_TBL_UPPER, 8'h00);
         sfr_rd(12'h123, 8'h00);
      end
   endtask

   task t_entry;
      begin
         i_prog.enter(1'b0);
         chk(24'(prog_mode_active), 24'h000001);
         chk(24'(io_hold_hiz), 24'h000001);
         chk(24'(low_voltage_mode_active), 24'h000000);
      end
   endtask

   task t_core;
      reg [7:0] b;
      begin
         i_prog.xfer(`SPVP_CMD_CORE, 16'h6EF6, 10, b);
         pop(`SPVP_KIND_CORE, 22'h000000, 16'h6EF6);
      end
   endtask

   task t_ptr;
      begin
         setp(22'h2A5C3B);
         sfr_wr(`SPVP_OFS_TBL_UPPER, 8'hEA);
         sfr_rd(`SPVP_OFS_TBL_UPPER, 8'h2A);
         sfr_rd(`SPVP_OFS_TBL_HIGH, 8'h5C);
         sfr_rd(`SPVP_OFS_TBL_LOW, 8'h3B);
         chk(24'(rd_addr), 24'h2A5C3B);
      end
   endtask

   task t_reads;
      reg [21:0] p;
      reg [7:0] b;
      reg [3:0] c;
      integer k;
      begin
         p = 22'h0012FE;
         setp(p);
         for (k = 0; k < 4; k = k + 1) begin
            c = `SPVP_CMD_RD + k[3:0];
            if (c == `SPVP_CMD_RD_PREINC) p = p + 22'h1;
            i_prog.xfer(c, 16'h00FF, 10, b);
            chk(24'(b), 24'(mem(p)));
            if (c == `SPVP_CMD_RD_POSTINC) p = p + 22'h1;
            if (c == `SPVP_CMD_RD_POSTDEC) p = p - 22'h1;
            chk(24'(rd_addr), 24'(p));
         end
         i_prog.xfer(`SPVP_CMD_SHIFT_LATCH, 16'h0000, 10, b);
         chk(24'(b), 24'(mem(p)));
      end
   endtask

   task t_writes;
      reg [21:0] p;
      reg [7:0] b;
      reg [3:0] c;
      integer k;
      begin
         p = 22'h000400;
         setp(p);
         for (k = 0; k < 4; k = k + 1) begin
            c = `SPVP_CMD_WR + k[3:0];
            i_prog.xfer(c, {12'hA5C, k[3:0]}, 10, b);
            chk(24'(serial_prog_data_oe_b), 24'h000001);
            pop(c[1] ? `SPVP_KIND_WRITE_PROG : `SPVP_KIND_WRITE, p, {12'hA5C, k[3:0]});
            if (c[1] ^ c[0]) p = p + 22'h2;
            chk(24'(rd_addr), 24'(p));
         end
      end
   endtask

   task t_stall;
      reg [7:0] b;
      integer k;
      begin
         setp(22'h000800);
         for (k = 0; k < 3; k = k + 1) i_prog.xfer(`SPVP_CMD_WR, {12'h5A0, k[3:0]}, 10, b);
         chk(24'(link_stall), 24'h000001);
         for (k = 0; k < 3; k = k + 1) pop(`SPVP_KIND_WRITE, 22'h000800, {12'h5A0, k[3:0]});
         chk(24'(link_stall), 24'h000000);
      end
   endtask

   task t_map;
      begin
         code_protect = 5'h1F;
         rdchk(22'h200003, mem(22'h200003));
         rdchk(22'h30000D, mem(22'h30000D));
         rdchk(22'h3FFFFE, DEV_CODE[7:0]);
         rdchk(22'h3FFFFF, DEV_CODE[15:8]);
         rdchk(22'h0001FF, 8'h00);
         rdchk(22'h001FFF, 8'h00);
         code_protect = 5'h04;
         rdchk(22'h001000, 8'h00);
         rdchk(22'h000FFF, mem(22'h000FFF));
         rdchk(22'h0001FF, mem(22'h0001FF));
         rdchk(22'h002000, 8'h00);
         code_protect = 5'h00;
      end
   endtask

   task t_lv;
      reg [7:0] b;
      begin
         i_prog.leave;
         chk(24'(prog_mode_active), 24'h000000);
         i_prog.enter(1'b1);
         chk(24'(prog_mode_active), 24'h000000);
         i_prog.leave;
         low_voltage_mode_enable_bit = 1'b1;
         i_prog.enter(1'b1);
         chk(24'(low_voltage_mode_active), 24'h000001);
         chk(24'(port_b5_select_pin_dedicated), 24'h000001);
         chk(24'(io_hold_hiz), 24'h000001);
         fork
            i_prog.xfer(`SPVP_CMD_CORE, 16'h0000, 60, b);
            #361 chk(24'(fourth_clock_high), 24'h000001);
         join
         pop(`SPVP_KIND_CORE, 22'h002000, 16'h0000);
         i_prog.leave;
      end
   endtask

   // ****************************************
   // Sequence and verdict
   // ****************************************
   task finish_test;
      begin
         if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      #400000;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      num_errors = num_errors + 1;
      finish_test;
   end

   initial begin
      rst_b = 1'b0;
      sfr_we = 1'b0;
      sfr_addr = 12'h000;
      sfr_wdata = 8'h00;
      cmd_ready = 1'b0;
      code_protect = 5'h00;
      low_voltage_mode_enable_bit = 1'b0;
      num_errors = 0;
      n_tests = 0;
      repeat (8) @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (4) step;
      t_reset;
      t_entry;
      t_core;
      t_ptr;
      t_reads;
      t_writes;
      t_stall;
      t_map;
      t_lv;
      finish_test;
   end
endmodule
